/* File: design/msr_acc_if.sv */
// link between the register block and one motion accumulator
interface msr_acc_if;
	logic clr;
	logic add_valid;
	logic [7:0] add_val;
	logic [7:0] count;

	modport ctrl (
		output clr,
		output add_valid,
		output add_val,
		input count
	);

	modport acc (
		input clr,
		input add_valid,
		input add_val,
		output count
	);
endinterface

/* File: design/msr_motion_acc.sv */
// saturating signed motion accumulator with clear on read
module msr_motion_acc (
	input wire logic clk,
	input wire logic ce,
	input wire logic rst,
	msr_acc_if.acc port
);
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic [7:0] sum;

	// signed add that sticks at -128 and +127 instead of wrapping
	function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] wide;
		wide = {a[7], a} + {b[7], b};
		if (wide[8] != wide[7]) begin
			return wide[8] ? 8'h80 : 8'h7F;
		end
		return wide[7:0];
	endfunction

	assign sum = sat_add(count_q, port.add_val);

	// a delta that arrives with the clearing read starts the new count, so it is never lost
	always_comb begin
		count_d = count_q;
		if (port.add_valid) begin
			count_d = port.clr ? port.add_val : sum;
		end else if (port.clr) begin
			count_d = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= msr_pkg::MOT_RESET_VAL;
		end else if (ce) begin
			count_q <= count_d;
		end
	end

	assign port.count = count_q;

	property p_saturate;
		@(posedge clk) disable iff (rst)
		ce && port.add_valid && !port.clr && count_q == 8'h7F && !port.add_val[7] |=> count_q == 8'h7F;
	endproperty
	a_saturate: assert property (p_saturate) else $error("motion count wrapped past +127"); // [RL7]

	property p_saturate_neg;
		@(posedge clk) disable iff (rst)
		ce && port.add_valid && !port.clr && count_q == 8'h80 && port.add_val[7] |=> count_q == 8'h80;
	endproperty
	a_saturate_neg: assert property (p_saturate_neg) else $error("motion count wrapped past -128"); // [RL8]
endmodule

/* File: design/msr_pkg.sv */
// shared constants of the motion sensor register block
package msr_pkg;
	// register indices; the bus byte address is four times the index
	localparam logic [7:0] IDX_CONFIG = 8'h1B;
	localparam logic [7:0] IDX_OPCTL = 8'h40;
	localparam logic [7:0] IDX_IDENT = 8'h41;
	localparam logic [7:0] IDX_MOT_Y = 8'h42;
	localparam logic [7:0] IDX_MOT_X = 8'h43;
	localparam logic [7:0] IDX_QUALITY = 8'h44;

	// field positions
	localparam int CFG_RESOLUTION_BIT = 7;
	localparam int OPC_RESET_BIT = 7;
	localparam int OPC_PD_BIT = 6;
	localparam int OPC_LED_BIT = 5;
	localparam int OPC_SLEEP_N_BIT = 0;
	localparam int ID_PART_LSB = 5;
	localparam int ID_STATE_BIT = 0;

	// values after reset
	localparam logic [7:0] CFG_RESET_VAL = 8'h00;
	localparam logic [7:0] OPC_RESET_VAL = 8'h20;
	localparam logic [7:0] MOT_RESET_VAL = 8'h00;
	localparam logic [7:0] QUAL_RESET_VAL = 8'h00;

	// writable bits: reserved bits read back as zero
	localparam logic [7:0] CFG_WR_MASK = 8'h80;
	localparam logic [7:0] OPC_WR_MASK = 8'hE1;

	// no-motion time before sleep, and its count of cycles
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned SLEEP_TIME_MS = 1000;
	localparam int unsigned SLEEP_CYCLES = (CLK_HZ / 1000) * SLEEP_TIME_MS;

	// operating states, one-hot
	typedef enum logic [2:0] {
		ST_NORMAL = 3'h1,
		ST_SLEEP = 3'h2,
		ST_PDOWN = 3'h4
	} msr_state_type;
endpackage

/* File: design/msr_sensor_regs.sv */
// register file, operating state and motion readout of the optical motion sensor
// Behaviour
// [RL1] config bit 7 picks 800 or 400 cpi
// [RL2] opctl: reset7, powerdown6, led5, sleep_n0
// [RL3] writing reset bit 1 resets whole chip
// [RL4] sleep after one second without motion
// [RL5] sleep ends on motion or wakeup
// [RL6] identity bits 7:5 hold fixed part code
// [RL7] Y count saturates, cleared by read
// [RL8] X count saturates, cleared by read
// [RL9] counts scale with selected resolution
// [RL10] quality register shows current frame quality
// [RL11] identity bit 0 shows normal or asleep
// [RL12] power-down bit places device in power-down
//
// Decided for this implementation: the Wishbone register port.
module msr_sensor_regs #(
	parameter int unsigned SLEEP_CYCLES = msr_pkg::SLEEP_CYCLES,
	parameter logic [2:0] PART_CODE = 3'h5 // arbitrary value
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic frame_valid,
	input wire logic [7:0] frame_dx,
	input wire logic [7:0] frame_dy,
	input wire logic [7:0] frame_quality,
	input wire logic wake_request,
	output logic resolution_select,
	output logic led_shutter_en,
	output logic power_down_request,
	output logic asleep
);
	logic ack_q;
	logic [31:0] dat_q;
	logic [31:0] dat_d;
	logic [7:0] cfg_q;
	logic [7:0] opc_q;
	logic [7:0] qual_q;
	logic soft_rst_q;
	logic [31:0] idle_cnt_q;
	logic [31:0] idle_cnt_d;
	msr_pkg::msr_state_type state_q;
	msr_pkg::msr_state_type state_d;

	msr_acc_if acc_x ();
	msr_acc_if acc_y ();

	// halve a delta at the coarse setting; the dropped half count is the price of no remainder store
	function automatic logic [7:0] scale_delta(input logic [7:0] d, input logic half);
		return half ? {d[7], d[7:1]} : d;
	endfunction

	function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
		return adr[9:2] == idx;
	endfunction

	// bus decode: a request is taken once per cycle of cyc and stb, answered one cycle later
	wire take = wb_cyc_i && wb_stb_i && !ack_q && ce;
	wire wr_byte = take && wb_we_i && wb_sel_i[0];
	wire rd = take && !wb_we_i;
	wire sel_cfg = hit(wb_adr_i, msr_pkg::IDX_CONFIG);
	wire sel_opc = hit(wb_adr_i, msr_pkg::IDX_OPCTL);
	wire sel_id = hit(wb_adr_i, msr_pkg::IDX_IDENT);
	wire sel_y = hit(wb_adr_i, msr_pkg::IDX_MOT_Y);
	wire sel_x = hit(wb_adr_i, msr_pkg::IDX_MOT_X);
	wire sel_q = hit(wb_adr_i, msr_pkg::IDX_QUALITY);
	wire wr_cfg = wr_byte && sel_cfg;
	wire wr_opc = wr_byte && sel_opc;

	// internal reset: the pin, or the self-clearing full chip reset
	wire int_rst = sys_rst || soft_rst_q; // [RL3]

	// control fields
	wire half_scale = cfg_q[msr_pkg::CFG_RESOLUTION_BIT]; // [RL1]
	wire pd_bit = opc_q[msr_pkg::OPC_PD_BIT]; // [RL2]
	wire sleep_en = !opc_q[msr_pkg::OPC_SLEEP_N_BIT]; // [RL2]
	wire is_normal = state_q == msr_pkg::ST_NORMAL;

	// motion seen in a frame; ignored while powered down
	wire frame_in = frame_valid && state_q != msr_pkg::ST_PDOWN;
	wire motion = frame_in && (frame_dx != 8'h00 || frame_dy != 8'h00);
	wire idle_done = idle_cnt_q == 32'(SLEEP_CYCLES - 1);

	// identity byte: part code, reserved zeros, operating state
	wire [7:0] ident = {PART_CODE, 4'h0, is_normal}; // [RL6] [RL11]

	// accumulator hookup: scaled deltas in, read clears
	assign acc_x.add_valid = frame_in;
	assign acc_x.add_val = scale_delta(frame_dx, half_scale); // [RL9]
	assign acc_x.clr = rd && sel_x; // [RL8]
	assign acc_y.add_valid = frame_in;
	assign acc_y.add_val = scale_delta(frame_dy, half_scale); // [RL9]
	assign acc_y.clr = rd && sel_y; // [RL7]

	msr_motion_acc u_acc_x (
		.clk(clk),
		.ce(ce),
		.rst(int_rst),
		.port(acc_x)
	);

	msr_motion_acc u_acc_y (
		.clk(clk),
		.ce(ce),
		.rst(int_rst),
		.port(acc_y)
	);

	// read mux; unmapped addresses answer with zero
	always_comb begin
		dat_d = 32'h0000_0000;
		if (sel_cfg) begin
			dat_d[7:0] = cfg_q;
		end else if (sel_opc) begin
			dat_d[7:0] = opc_q;
		end else if (sel_id) begin
			dat_d[7:0] = ident;
		end else if (sel_y) begin
			dat_d[7:0] = acc_y.count;
		end else if (sel_x) begin
			dat_d[7:0] = acc_x.count;
		end else if (sel_q) begin
			dat_d[7:0] = qual_q;
		end
	end

	// bus answer; only the pin reset touches it so a soft reset never drops an ack
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else if (ce) begin
			ack_q <= take;
			if (rd) begin
				dat_q <= dat_d;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// full chip reset pulse, one cycle after the write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			soft_rst_q <= 1'b0;
		end else if (ce) begin
			soft_rst_q <= wr_opc && wb_dat_i[msr_pkg::OPC_RESET_BIT]; // [RL3]
		end
	end

	// writable registers; the reset bit is never stored, so it reads back zero
	always_ff @(posedge clk) begin
		if (int_rst) begin
			cfg_q <= msr_pkg::CFG_RESET_VAL;
			opc_q <= msr_pkg::OPC_RESET_VAL;
		end else if (ce) begin
			if (wr_cfg) begin
				cfg_q <= wb_dat_i[7:0] & msr_pkg::CFG_WR_MASK; // [RL1]
			end
			if (wr_opc) begin
				opc_q <= wb_dat_i[7:0] & msr_pkg::OPC_WR_MASK & 8'h7F; // [RL2]
			end
		end
	end

	// quality of the latest frame
	always_ff @(posedge clk) begin
		if (int_rst) begin
			qual_q <= msr_pkg::QUAL_RESET_VAL;
		end else if (ce && frame_in) begin
			qual_q <= frame_quality; // [RL10]
		end
	end

	// operating state
	always_comb begin
		state_d = state_q;
		case (state_q)
			msr_pkg::ST_NORMAL: begin
				if (pd_bit) begin
					state_d = msr_pkg::ST_PDOWN; // [RL12]
				end else if (sleep_en && idle_done && !motion) begin
					state_d = msr_pkg::ST_SLEEP; // [RL4]
				end
			end
			msr_pkg::ST_SLEEP: begin
				if (pd_bit) begin
					state_d = msr_pkg::ST_PDOWN; // [RL12]
				end else if (motion || wake_request) begin
					state_d = msr_pkg::ST_NORMAL; // [RL5]
				end
			end
			msr_pkg::ST_PDOWN: begin
				if (!pd_bit) begin
					state_d = msr_pkg::ST_NORMAL; // [RL12]
				end
			end
			default: begin
				state_d = msr_pkg::ST_NORMAL;
			end
		endcase
	end

	// no-motion timer; runs only in normal mode with sleep enabled
	always_comb begin
		idle_cnt_d = 32'h0000_0000;
		if (is_normal && sleep_en && !motion && !idle_done) begin
			idle_cnt_d = idle_cnt_q + 32'h0000_0001; // [RL4]
		end
	end

	always_ff @(posedge clk) begin
		if (int_rst) begin
			state_q <= msr_pkg::ST_NORMAL;
			idle_cnt_q <= 32'h0000_0000;
		end else if (ce) begin
			state_q <= state_d;
			idle_cnt_q <= idle_cnt_d;
		end
	end

	assign resolution_select = half_scale; // [RL1]
	assign led_shutter_en = opc_q[msr_pkg::OPC_LED_BIT]; // [RL2]
	assign power_down_request = state_q == msr_pkg::ST_PDOWN; // [RL12]
	assign asleep = state_q == msr_pkg::ST_SLEEP;

	// helpers for the checks below
	wire wr_scale_bit = wb_dat_i[msr_pkg::CFG_RESOLUTION_BIT];
	wire wr_led_bit = wb_dat_i[msr_pkg::OPC_LED_BIT];
	wire wr_rst_bit = wb_dat_i[msr_pkg::OPC_RESET_BIT];
	wire wr_pd_bit = wb_dat_i[msr_pkg::OPC_PD_BIT];
	wire [7:0] exp_dy = scale_delta(frame_dy, half_scale);
	wire [7:0] exp_dx = scale_delta(frame_dx, half_scale);

	property p_cfg_resolution;
		@(posedge clk) disable iff (sys_rst)
		wr_cfg ##1 !soft_rst_q |-> resolution_select == $past(wr_scale_bit);
	endproperty
	a_cfg_resolution: assert property (p_cfg_resolution) else $error("resolution select did not follow write"); // [RL1]

	property p_led_bit;
		@(posedge clk) disable iff (sys_rst)
		wr_opc && !wr_rst_bit |=> led_shutter_en == $past(wr_led_bit);
	endproperty
	a_led_bit: assert property (p_led_bit) else $error("led shutter bit not at bit 5"); // [RL2]

	property p_chip_reset;
		@(posedge clk) disable iff (sys_rst)
		wr_opc && wr_rst_bit |=> soft_rst_q ##1 cfg_q == msr_pkg::CFG_RESET_VAL && opc_q == msr_pkg::OPC_RESET_VAL
			&& is_normal && acc_x.count == 8'h00;
	endproperty
	a_chip_reset: assert property (p_chip_reset) else $error("full chip reset did not restore defaults"); // [RL3]

	property p_sleep_entry;
		@(posedge clk) disable iff (int_rst)
		ce && is_normal && sleep_en && idle_done && !motion && !pd_bit |=> asleep;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep after idle time"); // [RL4]

	property p_no_early_sleep;
		@(posedge clk) disable iff (int_rst)
		is_normal && !idle_done |=> !asleep;
	endproperty
	a_no_early_sleep: assert property (p_no_early_sleep) else $error("sleep before idle time ran out"); // [RL4]

	property p_wake;
		@(posedge clk) disable iff (int_rst)
		ce && asleep && !pd_bit && (motion || wake_request) |=> is_normal ##1 ident[msr_pkg::ID_STATE_BIT];
	endproperty
	a_wake: assert property (p_wake) else $error("sleep not left on motion or wakeup"); // [RL5] [RL11]

	property p_ident_read;
		@(posedge clk) disable iff (sys_rst)
		rd && sel_id |=> wb_ack_o && wb_dat_o[7:5] == PART_CODE && wb_dat_o[4:1] == 4'h0
			&& wb_dat_o[0] == $past(is_normal);
	endproperty
	a_ident_read: assert property (p_ident_read) else $error("identity read wrong"); // [RL6] [RL11]

	property p_y_clear;
		@(posedge clk) disable iff (int_rst)
		rd && sel_y && !frame_in |=> acc_y.count == 8'h00;
	endproperty
	a_y_clear: assert property (p_y_clear) else $error("Y count not cleared by read"); // [RL7]

	property p_x_clear;
		@(posedge clk) disable iff (int_rst)
		rd && sel_x && frame_in |=> acc_x.count == $past(acc_x.add_val);
	endproperty
	a_x_clear: assert property (p_x_clear) else $error("X delta lost on clearing read"); // [RL8]

	property p_scale;
		@(posedge clk) disable iff (int_rst)
		ce && frame_in && acc_y.count == 8'h00 && !(rd && sel_y) |=> acc_y.count == $past(exp_dy);
	endproperty
	a_scale: assert property (p_scale) else $error("Y delta not scaled by resolution"); // [RL9]

	property p_quality;
		@(posedge clk) disable iff (int_rst)
		ce && frame_in |=> qual_q == $past(frame_quality);
	endproperty
	a_quality: assert property (p_quality) else $error("quality not taken from frame"); // [RL10]

	property p_power_down;
		@(posedge clk) disable iff (int_rst)
		wr_opc && wr_pd_bit && !wr_rst_bit ##1 ce |=> power_down_request;
	endproperty
	a_power_down: assert property (p_power_down) else $error("power-down not entered"); // [RL12]

	property p_cfg_reserved;
		@(posedge clk) disable iff (sys_rst)
		rd && sel_cfg |=> wb_dat_o[6:0] == 7'h00;
	endproperty
	a_cfg_reserved: assert property (p_cfg_reserved) else $error("configuration reserved bits read nonzero"); // [RL1]

	property p_opc_reserved;
		@(posedge clk) disable iff (sys_rst)
		rd && sel_opc |=> wb_dat_o[7] == 1'b0 && wb_dat_o[4:1] == 4'h0;
	endproperty
	a_opc_reserved: assert property (p_opc_reserved) else $error("control reset or reserved bits read nonzero"); // [RL2]

	property p_x_scale;
		@(posedge clk) disable iff (int_rst)
		ce && frame_in && acc_x.count == 8'h00 && !(rd && sel_x) |=> acc_x.count == $past(exp_dx);
	endproperty
	a_x_scale: assert property (p_x_scale) else $error("X delta not scaled by resolution"); // [RL9]

	property p_sleep_hold;
		@(posedge clk) disable iff (int_rst)
		ce && asleep && !pd_bit && !motion && !wake_request |=> asleep;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without motion or wakeup"); // [RL5]

	property p_pd_drop;
		@(posedge clk) disable iff (int_rst)
		power_down_request && frame_valid && !(rd && sel_x) |=> acc_x.count == $past(acc_x.count);
	endproperty
	a_pd_drop: assert property (p_pd_drop) else $error("frame counted while powered down"); // [RL12]
endmodule

/* File: tb/msr_frame_src.sv */
// partner model: the optical front end that hands one frame result per request
module msr_frame_src (
	input wire logic clk,
	input wire logic send,
	input wire logic [7:0] dx,
	input wire logic [7:0] dy,
	input wire logic [7:0] q,
	output logic frame_valid,
	output logic [7:0] frame_dx,
	output logic [7:0] frame_dy,
	output logic [7:0] frame_quality
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		frame_valid = 1'b0;
		frame_dx = 8'h00;
		frame_dy = 8'h00;
		frame_quality = 8'h00;
	end
	// outside a frame the data lines carry junk, so a design that reads them late sees nonsense
	always @(posedge clk) begin
		frame_valid <= send;
		frame_dx <= send ? dx : ~frame_dx;
		frame_dy <= send ? dy : ~frame_dy;
		frame_quality <= send ? q : ~frame_quality;
	end
endmodule

/* File: tb/msr_sensor_regs_bench.sv */
// self-checking bench for the motion sensor register block
module msr_sensor_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wake = 1'b0, f_send = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_i = 32'h00000000;
	logic [7:0] f_dx = 8'h00, f_dy = 8'h00, f_q = 8'h00, rd;
	wire frame_valid, wb_ack_o, resolution_select, led_shutter_en, power_down_request, asleep;
	wire [7:0] frame_dx, frame_dy, frame_quality;
	wire [31:0] wb_dat_o;
	int fails = 0;
	int cmp_count = 0;

	initial forever #12.5 clk = ~clk;

	// short idle time so the sleep path is reached in a few cycles
	msr_sensor_regs #(.SLEEP_CYCLES(20)) msr_sensor_regs_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_valid(frame_valid), .frame_dx(frame_dx),
		.frame_dy(frame_dy), .frame_quality(frame_quality), .wake_request(wake),
		.resolution_select(resolution_select), .led_shutter_en(led_shutter_en),
		.power_down_request(power_down_request), .asleep(asleep));

	msr_frame_src msr_frame_src_inst (.clk(clk), .send(f_send), .dx(f_dx), .dy(f_dy), .q(f_q),
		.frame_valid(frame_valid), .frame_dx(frame_dx), .frame_dy(frame_dy), .frame_quality(frame_quality));

	function automatic logic [9:0] ra(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction

	task end_sim;
		$display("mismatches %0d comparisons %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task tick(input int k);
		repeat (k) @(posedge clk);
	endtask

	task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task chk1(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask

	// one classic cycle; the answer is taken at the edge that samples ack high
	task bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_i <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			fails++;
			end_sim();
		end else begin
			@(posedge clk);
		end
	endtask

	task wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, ra(idx), d, 4'h1);
	endtask

	task rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, ra(idx), 8'h00, 4'hF);
		chk8(nm, e, rd);
	endtask

	// one frame from the front end, then wait until the counts have settled
	task frame(input logic [7:0] x, input logic [7:0] y, input logic [7:0] q);
		f_send <= 1'b1;
		f_dx <= x;
		f_dy <= y;
		f_q <= q;
		@(posedge clk);
		f_send <= 1'b0;
		tick(3);
	endtask

	// hang guard
	initial begin
		tick(20000);
		fails++;
		end_sim();
	end

	initial begin
		tick(12);
		sys_rst <= 1'b0;
		tick(1);
		chk1("resolution", 1'b0, resolution_select);
		chk1("led", 1'b1, led_shutter_en);
		rchk("config", msr_pkg::IDX_CONFIG, 8'h00);
		rchk("opctl", msr_pkg::IDX_OPCTL, 8'h20);
		rchk("ident", msr_pkg::IDX_IDENT, 8'hA1);
		rchk("quality", msr_pkg::IDX_QUALITY, 8'h00);
		// reserved bits drop, sleep is disabled for the motion tests
		wr(msr_pkg::IDX_OPCTL, 8'h3F);
		rchk("opctl", msr_pkg::IDX_OPCTL, 8'h21);
		bus(1'b1, ra(msr_pkg::IDX_CONFIG), 8'hFF, 4'h0);
		rchk("config", msr_pkg::IDX_CONFIG, 8'h00);
		wr(msr_pkg::IDX_CONFIG, 8'hFF);
		rchk("config", msr_pkg::IDX_CONFIG, 8'h80);
		chk1("resolution", 1'b1, resolution_select);
		frame(8'h05, 8'hFD, 8'h9C);
		rchk("x half", msr_pkg::IDX_MOT_X, 8'h02);
		rchk("y half", msr_pkg::IDX_MOT_Y, 8'hFE);
		rchk("quality", msr_pkg::IDX_QUALITY, 8'h9C);
		wr(msr_pkg::IDX_CONFIG, 8'h00);
		frame(8'h05, 8'hFD, 8'h10);
		// a frame that meets the clearing read must start the new count, not vanish
		f_send <= 1'b1;
		f_dx <= 8'h03;
		f_dy <= 8'h00;
		@(posedge clk);
		f_send <= 1'b0;
		rchk("x", msr_pkg::IDX_MOT_X, 8'h05);
		rchk("x kept", msr_pkg::IDX_MOT_X, 8'h03);
		rchk("y", msr_pkg::IDX_MOT_Y, 8'hFD);
		rchk("x cleared", msr_pkg::IDX_MOT_X, 8'h00);
		repeat (3) frame(8'h7F, 8'h80, 8'hFF);
		rchk("x sat", msr_pkg::IDX_MOT_X, 8'h7F);
		rchk("y sat", msr_pkg::IDX_MOT_Y, 8'h80);
		rchk("quality", msr_pkg::IDX_QUALITY, 8'hFF);
		wr(msr_pkg::IDX_IDENT, 8'h00);
		rchk("ident", msr_pkg::IDX_IDENT, 8'hA1);
		bus(1'b0, 10'h3FC, 8'h00, 4'hF);
		chk8("unmapped", 8'h00, rd);
		// frames are dropped while powered down
		wr(msr_pkg::IDX_OPCTL, 8'h61);
		tick(1);
		chk1("power down", 1'b1, power_down_request);
		rchk("ident pd", msr_pkg::IDX_IDENT, 8'hA0);
		frame(8'h09, 8'h09, 8'h33);
		wr(msr_pkg::IDX_OPCTL, 8'h21);
		tick(2);
		chk1("power down", 1'b0, power_down_request);
		rchk("x pd", msr_pkg::IDX_MOT_X, 8'h00);
		rchk("quality pd", msr_pkg::IDX_QUALITY, 8'hFF);
		// idle timeout, then wake by request and by motion
		wr(msr_pkg::IDX_OPCTL, 8'h20);
		// the write lands two edges back; the twentieth idle edge from it is the last awake one
		tick(18);
		chk1("asleep early", 1'b0, asleep);
		tick(1);
		chk1("asleep", 1'b1, asleep);
		rchk("ident sleep", msr_pkg::IDX_IDENT, 8'hA0);
		wake <= 1'b1;
		tick(1);
		wake <= 1'b0;
		tick(2);
		chk1("woken", 1'b0, asleep);
		tick(25);
		chk1("asleep", 1'b1, asleep);
		frame(8'h01, 8'h00, 8'h40);
		chk1("woken", 1'b0, asleep);
		rchk("x wake", msr_pkg::IDX_MOT_X, 8'h01);
		// with the enable low a frame passes unseen and nothing moves
		ce <= 1'b0;
		frame(8'h04, 8'h04, 8'h55);
		ce <= 1'b1;
		rchk("x frozen", msr_pkg::IDX_MOT_X, 8'h00);
		rchk("quality frozen", msr_pkg::IDX_QUALITY, 8'h40);
		// soft reset brings back the config and opctl defaults
		wr(msr_pkg::IDX_CONFIG, 8'h80);
		wr(msr_pkg::IDX_OPCTL, 8'h01);
		chk1("led off", 1'b0, led_shutter_en);
		wr(msr_pkg::IDX_OPCTL, 8'h80);
		tick(2);
		rchk("config", msr_pkg::IDX_CONFIG, 8'h00);
		rchk("opctl", msr_pkg::IDX_OPCTL, 8'h20);
		chk1("led", 1'b1, led_shutter_en);
		chk1("resolution", 1'b0, resolution_select);
		end_sim();
	end
endmodule
